// *** design/sbsc_front.sv ***
// Control front end of a flow-through burst SRAM.
// Assumes the host drives all synchronous pins relative to clk_sys and
// that the data pin wire is resolved outside from dq_out_en_n.
`timescale 1ns/10ps
`default_nettype none

// Contract
// - Register every synchronous input on rising edge
// - Advance low steps burst counter
// - Advance sampled synchronously, steps burst address
// - All-bytes write ignores lane selects
// - Three chip selects decide selection
// - Chip selects sampled only at address load
// - Output enable sets data direction asynchronously; code registers it on clk_sys, lagging up to one clock
// - Processor strobe loads address, seeds counter
// - Both strobes low: processor strobe wins
// - Processor strobe ignored when primary select high
// - Output enable high tristates; masked first read
// - Lane select needs byte-write qualify low
// - Controller strobe loads address, seeds counter
module sbsc_front #(
  parameter int ADDR_W = sbsc_pkg::ADDR_W,
  parameter int DATA_W = sbsc_pkg::DATA_W,
  parameter int LANES  = sbsc_pkg::LANES
) (
  input  wire logic                clk_sys,
  input  wire logic                resetn,
  input  wire logic [ADDR_W-1:0]   addr_in,
  input  wire logic [DATA_W-1:0]   dq_in,
  input  wire sbsc_pkg::sbsc_ctl_s ctl_in,
  input  wire logic                out_enable_n,
  input  wire logic [DATA_W-1:0]   rd_data,
  output logic      [DATA_W-1:0]   dq_out,
  output logic                     dq_out_en_n,
  output sbsc_pkg::sbsc_req_s      req,
  output logic      [DATA_W-1:0]   wr_data,
  output logic                     selected
);

  localparam int BW = sbsc_pkg::BURST_W;

  // Registered pin images
  sbsc_pkg::sbsc_ctl_s   ctl_reg;
  logic [ADDR_W-1:0]     addr_pin_reg;
  logic [DATA_W-1:0]     dq_reg;
  // Front-end state
  logic [ADDR_W-1:0]     base_reg;
  logic [ADDR_W-1:0]     base_next;
  logic                  sel_reg;
  logic                  sel_next;
  sbsc_pkg::sbsc_state_e state_reg;
  sbsc_pkg::sbsc_state_e state_next;
  sbsc_pkg::sbsc_req_s   req_reg;
  sbsc_pkg::sbsc_req_s   req_next;
  logic                  first_read_reg;
  logic                  first_read_next;
  logic [DATA_W-1:0]     dq_out_reg;
  logic                  oe_n_reg;
  logic [BW-1:0]         burst_cnt;

  // Combine the three chip selects into one term
  function automatic logic chip_on(input sbsc_pkg::sbsc_ctl_s c);
    chip_on = !c.chip_sel_primary_n && c.chip_sel_expand_hi &&
              !c.chip_sel_expand_lo_n;
  endfunction

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      ctl_reg      <= '{proc_addr_strobe_n: 1'b1, ctrl_addr_strobe_n: 1'b1,
                        burst_advance_n: 1'b1, all_bytes_write_n: 1'b1,
                        byte_write_qualify_n: 1'b1,
                        byte_lane_select_n: '1, chip_sel_primary_n: 1'b1,
                        chip_sel_expand_hi: 1'b0,
                        chip_sel_expand_lo_n: 1'b1};
      addr_pin_reg <= sbsc_pkg::ADDR_RST;
      dq_reg       <= '0;
    end else begin
      ctl_reg      <= ctl_in;
      addr_pin_reg <= addr_in;
      dq_reg       <= dq_in;
    end
  end

  // Strobe resolution on the registered pins
  wire proc_ld  = !ctl_reg.proc_addr_strobe_n;
  // Primary select high masks the processor strobe
  wire proc_ok  = proc_ld && !ctl_reg.chip_sel_primary_n;
  // Processor strobe takes priority over controller
  wire ctrl_ok  = !ctl_reg.ctrl_addr_strobe_n && !proc_ld;
  // Either honoured strobe loads a new address
  wire addr_ld  = proc_ok || ctrl_ok;
  // Chip selects only matter at a load
  wire sel_now  = addr_ld ? chip_on(ctl_reg) : sel_reg;
  // Advance low steps the burst when no load
  wire step     = !addr_ld && sel_reg && !ctl_reg.burst_advance_n;
  // Writes are never taken with an honoured processor strobe, whose cycle is a read
  wire wr_any   = !proc_ok &&
                  (!ctl_reg.all_bytes_write_n ||
                   !ctl_reg.byte_write_qualify_n);
  // Lane select qualified by byte-write enable
  wire [LANES-1:0] lane_we = !ctl_reg.all_bytes_write_n ? {LANES{1'b1}} :
                   (!ctl_reg.byte_write_qualify_n ?
                    ~ctl_reg.byte_lane_select_n : {LANES{1'b0}});

  // Seed the counter with the low address bits
  // Two-bit counter wraps inside the group
  sbsc_burst_cnt #(
    .W (BW)
  ) u_cnt (
    .clk_sys (clk_sys),
    .resetn  (resetn),
    .load    (addr_ld),
    .step    (step),
    .seed    (addr_pin_reg[BW-1:0]),
    .count   (burst_cnt)
  );

  // Next-state decode for selection, base address and request
  assign base_next = addr_ld ? addr_pin_reg : base_reg;
  assign sel_next  = sel_now;

  // Upper bits fixed; low bits follow the counter
  wire [ADDR_W-1:0] cur_addr = addr_ld ?
       addr_pin_reg :
       {base_reg[ADDR_W-1:BW], (step ? BW'(burst_cnt + 1'b1) : burst_cnt)};

  always_comb begin
    req_next         = '0;
    req_next.valid   = sel_now && (addr_ld || step || wr_any);
    req_next.write   = sel_now && wr_any && (|lane_we);
    req_next.lane_we = req_next.write ? lane_we : {LANES{1'b0}};
    req_next.addr    = cur_addr;
  end

  // Gray-coded front-end state
  always_comb begin
    case (state_reg)
      sbsc_pkg::SBSC_DESEL:
        state_next = (addr_ld && sel_now) ? sbsc_pkg::SBSC_LOAD
                                          : sbsc_pkg::SBSC_DESEL;
      sbsc_pkg::SBSC_LOAD,
      sbsc_pkg::SBSC_BURST:
        state_next = !sel_now ? sbsc_pkg::SBSC_DESEL
                   : (addr_ld ? sbsc_pkg::SBSC_LOAD
                              : sbsc_pkg::SBSC_BURST);
      default:
        state_next = sbsc_pkg::SBSC_DESEL;
    endcase
  end

  // Mask output enable on first read after deselect
  assign first_read_next = (state_reg == sbsc_pkg::SBSC_DESEL) &&
                           addr_ld && sel_now && !wr_any;

  // Front-end state registers
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      base_reg       <= sbsc_pkg::ADDR_RST;
      sel_reg        <= 1'b0;
      state_reg      <= sbsc_pkg::SBSC_DESEL;
      req_reg        <= '0;
      first_read_reg <= 1'b0;
    end else begin
      base_reg       <= base_next;
      sel_reg        <= sel_next;
      state_reg      <= state_next;
      req_reg        <= req_next;
      first_read_reg <= first_read_next;
    end
  end

  // Write data is registered in step with the request, landing in the same cycle
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      wr_data <= '0;
    end else begin
      wr_data <= dq_reg;
    end
  end

  // Direction from output enable, sampled on every rising edge.
  // Trade-off: outputs must come from flops, so the pin enable lags
  // the asynchronous input by at most one clock period.
  // High output enable, masked first read or a write request tristates
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      oe_n_reg   <= 1'b1;
      dq_out_reg <= '0;
    end else begin
      oe_n_reg   <= out_enable_n || first_read_next || req_next.write;
      dq_out_reg <= rd_data;
    end
  end

  assign dq_out      = dq_out_reg;
  assign dq_out_en_n = oe_n_reg;
  assign req         = req_reg;
  assign selected    = sel_reg;

  // Assertions
  // Masked strobe never loads
  proc_mask_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    (proc_ld && ctl_reg.chip_sel_primary_n) |-> !proc_ok)
    else $error("processor strobe taken with primary select high");
  gw_lanes_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    (sel_now && wr_any && !ctl_reg.all_bytes_write_n) |=>
      req_reg.lane_we == {LANES{1'b1}})
    else $error("global write did not enable all lanes");
  lane_qual_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    (ctl_reg.all_bytes_write_n && ctl_reg.byte_write_qualify_n) |=>
      req_reg.lane_we == '0)
    else $error("lane written without qualify");
  prio_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    (proc_ld && !ctl_reg.ctrl_addr_strobe_n) |-> !ctrl_ok)
    else $error("controller strobe honoured with processor strobe");
  load_addr_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    addr_ld |=> (base_reg == $past(addr_pin_reg) &&
                 burst_cnt == $past(addr_pin_reg[BW-1:0])))
    else $error("address or counter not loaded");
  step_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    step |=> burst_cnt == BW'($past(burst_cnt) + 1'b1))
    else $error("burst counter did not step");
  upper_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    (!addr_ld && sel_now) |=>
      req_reg.addr[ADDR_W-1:BW] == base_reg[ADDR_W-1:BW])
    else $error("upper address bits moved in burst");
  sel_hold_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    !addr_ld |=> sel_reg == $past(sel_reg))
    else $error("selection changed without a load");
  oe_dir_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    out_enable_n |=> dq_out_en_n)
    else $error("data pins driven with output enable high");

endmodule
`default_nettype wire

// *** design/sbsc_pkg.sv ***
// Package for the synchronous burst SRAM control front end.
// Assumes a single rising-edge clock; all users write sbsc_pkg::name.
package sbsc_pkg;

  localparam int ADDR_W      = 18;   // Word address width
  localparam int DATA_W      = 36;   // Data word width
  localparam int LANES       = 4;    // Byte lanes
  localparam int BURST_W     = 2;    // Burst counter width

  // Reset values of the front-end state
  localparam logic [ADDR_W-1:0]  ADDR_RST  = 18'h00000;
  localparam logic [BURST_W-1:0] BURST_RST = 2'h0;

  // Registered control strobes, all as sampled at the pins
  typedef struct packed {
    logic             proc_addr_strobe_n;
    logic             ctrl_addr_strobe_n;
    logic             burst_advance_n;
    logic             all_bytes_write_n;
    logic             byte_write_qualify_n;
    logic [LANES-1:0] byte_lane_select_n;
    logic             chip_sel_primary_n;
    logic             chip_sel_expand_hi;
    logic             chip_sel_expand_lo_n;
  } sbsc_ctl_s;

  // Access request towards the memory array
  typedef struct packed {
    logic              valid;
    logic              write;
    logic [LANES-1:0]  lane_we;
    logic [ADDR_W-1:0] addr;
  } sbsc_req_s;

  // Front-end states: Gray coded along idle -> load -> burst
  typedef enum logic [1:0] {
    SBSC_DESEL = 2'b00,
    SBSC_LOAD  = 2'b01,
    SBSC_BURST = 2'b11
  } sbsc_state_e;

endpackage

// *** design/sbsc_burst_cnt.sv ***
// Two-bit burst counter that wraps within the loaded four-word group.
// Assumes load and step come from registered strobes on the same clock.
`timescale 1ns/10ps
`default_nettype none
module sbsc_burst_cnt #(
  parameter int W = sbsc_pkg::BURST_W
) (
  input  wire logic         clk_sys,
  input  wire logic         resetn,
  input  wire logic         load,
  input  wire logic         step,
  input  wire logic [W-1:0] seed,
  output logic      [W-1:0] count
);

  logic [W-1:0] count_reg;
  logic [W-1:0] count_next;

  // Load wins over step; step wraps naturally in W bits
  assign count_next = load ? seed : (step ? W'(count_reg + 1'b1) : count_reg);
  assign count      = count_reg;

  // Counter register
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      count_reg <= '0;
    end else begin
      count_reg <= count_next;
    end
  end

endmodule
`default_nettype wire

// *** verification/sbsc_host_model.sv ***
// Far side of the front end: resolves the shared data pins, serves reads.
// Assumes the front end drives dq_out only while dq_out_en_n is low.
`timescale 1ns/10ps
`default_nettype none
module sbsc_host_model (
  input  wire logic                        dq_out_en_n,
  input  wire logic [sbsc_pkg::DATA_W-1:0] dq_out,
  input  wire logic [sbsc_pkg::DATA_W-1:0] host_dq,
  input  wire sbsc_pkg::sbsc_req_s         req,
  output logic      [sbsc_pkg::DATA_W-1:0] dq_in,
  output logic      [sbsc_pkg::DATA_W-1:0] rd_data
);
  // Host drives the wire only once the device has let it go
  assign dq_in   = dq_out_en_n ? host_dq : dq_out;
  // Word built from its address, so a stale read is easy to spot
  assign rd_data = {~req.addr, req.addr};
endmodule
`default_nettype wire

// *** verification/testbench.sv ***
// Self-checking bench for the burst SRAM control front end.
// Assumes pins are taken at one edge and answered at the next one.
`timescale 1ns/10ps
`default_nettype none
module testbench;
  typedef struct packed {
    logic [11:0] c;
    logic        vld;
    logic        wr;
    logic [3:0]  we;
    logic        sel;
  } sbsc_tb_row_s;
  // Strobes and advance high, all chip selects active
  localparam logic [11:0] IDLE = 12'hffa;
  // Advance low with the high-side select off, which must not matter
  localparam logic [11:0] BURST_ADVANCE_N  = 12'hdf8;
  logic                   clk_sys      = 1'b0;
  logic                   resetn       = 1'b0;
  logic [17:0]            addr_in      = 18'h00000;
  logic [35:0]            host_dq      = 36'h000000000;
  sbsc_pkg::sbsc_ctl_s    ctl          = IDLE;
  logic                   out_enable_n = 1'b1;
  logic [35:0]            dq_in;
  logic [35:0]            rd_data;
  logic [35:0]            dq_out;
  logic [35:0]            wr_data;
  logic                   dq_out_en_n;
  logic                   selected;
  sbsc_pkg::sbsc_req_s    req;
  int                     mismatches   = 0;
  int                     tests_run    = 0;
  logic [17:0]            a;
  logic [17:0]            prev;
  // Pins, then valid, write, lane enables, selected
  sbsc_tb_row_s           rows [11] = '{
    {12'hb72, 7'b11_0001_1}, {12'hafa, 7'b11_1111_1},
    {12'h702, 7'b10_0000_1}, {12'h302, 7'b10_0000_1},
    {12'h7fe, 7'b00_0000_1}, {12'hbf8, 7'b00_0000_0},
    {12'hbfa, 7'b10_0000_1}, {12'hbfe, 7'b00_0000_0},
    {12'hbfb, 7'b00_0000_0}, {12'hb52, 7'b11_0101_1},
    {12'hb82, 7'b10_0000_1}};

  sbsc_front i_dut (
    .clk_sys      (clk_sys),
    .resetn       (resetn),
    .addr_in      (addr_in),
    .dq_in        (dq_in),
    .ctl_in       (ctl),
    .out_enable_n (out_enable_n),
    .rd_data      (rd_data),
    .dq_out       (dq_out),
    .dq_out_en_n  (dq_out_en_n),
    .req          (req),
    .wr_data      (wr_data),
    .selected     (selected)
  );

  sbsc_host_model i_host (
    .dq_out_en_n (dq_out_en_n),
    .dq_out      (dq_out),
    .host_dq     (host_dq),
    .req         (req),
    .dq_in       (dq_in),
    .rd_data     (rd_data)
  );

  // Free-running 250 MHz clock
  always #2 clk_sys = ~clk_sys;

  // Verdict and end of run, shared with the watchdog
  task automatic end_of_test();
    if (mismatches == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Compare one value, four-state, and count it
  task automatic check(input logic [35:0] seen, input logic [35:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  task automatic step(input logic [11:0] c, input logic [17:0] ad,
                      input logic oe);
    @(posedge clk_sys);
    #1;
    ctl          = c;
    addr_in      = ad;
    host_dq      = {18'h00000, ad};
    out_enable_n = oe;
  endtask

  // Main sequence: reset, table of single loads, then a wrapping burst
  initial begin
    repeat (3) @(posedge clk_sys);
    #1;
    resetn = 1'b1;
    check(dq_out_en_n, 1'b1);
    check(selected, 1'b0);
    foreach (rows[i]) begin
      a = 18'h12340 | 18'(i);
      step(rows[i].c, a, 1'b1);
      step(IDLE, a, 1'b1);
      step(IDLE, a, 1'b1);
      check(req.valid, rows[i].vld);
      check(selected, rows[i].sel);
      if (rows[i].vld) begin
        check(req.addr, a);
        check(req.write, rows[i].wr);
        check(req.lane_we, rows[i].we);
      end
      if (rows[i].wr) begin
        check(wr_data, host_dq);
      end
    end
    // Burst from a group's last word; the read follows a deselect
    a    = 18'h2abc7;
    prev = a;
    step(12'hbf8, a, 1'b1);
    step(12'hbfa, a, 1'b0);
    step(BURST_ADVANCE_N, a, 1'b0);
    step(BURST_ADVANCE_N, a, 1'b0);
    check(req.addr, a);
    check(dq_out_en_n, 1'b1);
    for (int k = 1; k <= 4; k++) begin
      step(BURST_ADVANCE_N, a, 1'b0);
      check(req.addr, {a[17:2], a[1:0] + 2'(k)});
      check(req.valid, 1'b1);
      check(selected, 1'b1);
      check(dq_out_en_n, 1'b0);
      check(dq_out, {~prev, prev});
      prev = {a[17:2], a[1:0] + 2'(k)};
    end
    repeat (3) step(IDLE, a, 1'b1);
    check(dq_out_en_n, 1'b1);
    end_of_test();
  end

  // Watchdog: the whole sequence needs well under 1000 cycles
  initial begin
    #4000;
    mismatches++;
    end_of_test();
  end
endmodule
`default_nettype wire
